// [include/oec_cfg.svh]
// Constants for the OTG event and carkit register block.
// Assumes inclusion by bare name from the package and design file.
`ifndef OEC_CFG_SVH
`define OEC_CFG_SVH
`define OEC_ADDR_W 6
`define OEC_RISE_BASE 6'h0D
`define OEC_FALL_BASE 6'h10
`define OEC_LIVE_ADDR 6'h13
`define OEC_LATCH_ADDR 6'h14
`define OEC_DEBUG_ADDR 6'h15
`define OEC_SCRATCH_BASE 6'h16
`define OEC_KIT_BASE 6'h19
`define OEC_OFS_SET 6'h01
`define OEC_OFS_CLR 6'h02
`define OEC_EVT_W 5
`define OEC_ENABLE_RST 5'h1F
`define OEC_SCRATCH_RST 8'h00
`define OEC_KIT_RST 6'h00
`define OEC_KIT_W 6
`define OEC_HD_BIT 0
`endif

// [include/oec_pkg.sv]
// Types for the OTG event and carkit register block.
// Assumes oec_cfg.svh is on the include path.
`include "oec_cfg.svh"
package oec_pkg;
   // Monitored comparator levels, bit 4 first
   typedef struct packed {
      logic ident_pin_low;
      logic session_ended;
      logic session_present;
      logic bus_power_good;
      logic host_detach;
   } oec_mon_t;
   // Carkit switch fields, bits 6 to 1 of the control byte
   typedef struct packed {
      logic mic_route;
      logic right_audio_route;
      logic left_audio_route;
      logic uart_rx_route;
      logic uart_tx_route;
      logic ident_pull_low_drive;
   } oec_kit_t;
   typedef enum logic [1:0] {
      OEC_WR_PLAIN,
      OEC_WR_SET,
      OEC_WR_CLEAR,
      OEC_WR_NONE
   } oec_wr_t;
endpackage

// [logic/oec_regs.sv]
// OTG event registers, scratch byte and carkit switch control.
// Assumes register accesses from the link logic on clk_in; comparators
// and line state come from the analog side and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "oec_cfg.svh"

module oec_regs (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [`OEC_ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [4:0] mon_in,
   input wire logic [1:0] line_level_in,
   input wire logic host_mode_in,
   input wire logic kit_mode_set_in,
   input wire logic kit_mode_exit_in,
   input wire logic uart_tx_data_in,
   input wire logic uart_rx_line_in,
   output logic kit_interface_mode_out,
   output logic uart_rx_data_out,
   output logic dm_tx_switch_out,
   output logic dp_rx_switch_out,
   output logic ident_pull_low_drive_out,
   output logic left_audio_pin_switch_out,
   output logic right_mic_pin_switch_out,
   output logic left_audio_uart_out,
   output logic right_mic_uart_out,
   output logic se_rx_disable_out,
   output logic event_pending_out
);

   // ******************************
   // Decode
   // ******************************
   function automatic oec_pkg::oec_wr_t wr_kind(input logic [`OEC_ADDR_W-1:0] a,
                                                input logic [`OEC_ADDR_W-1:0] base);
      if (a == base)
         return oec_pkg::OEC_WR_PLAIN;
      else if (a == base + `OEC_OFS_SET)
         return oec_pkg::OEC_WR_SET;
      else if (a == base + `OEC_OFS_CLR)
         return oec_pkg::OEC_WR_CLEAR;
      return oec_pkg::OEC_WR_NONE;
   endfunction

   function automatic logic [7:0] wr_apply(input oec_pkg::oec_wr_t k, input logic [7:0] cur,
                                           input logic [7:0] wd);
      unique case (k)
         oec_pkg::OEC_WR_PLAIN: return wd;
         oec_pkg::OEC_WR_SET: return cur | wd;
         oec_pkg::OEC_WR_CLEAR: return cur & ~wd;
         oec_pkg::OEC_WR_NONE: return cur;
      endcase
   endfunction

   oec_pkg::oec_wr_t rise_k, fall_k, scr_k, kit_k;
   assign rise_k = wr_kind(reg_addr_in, `OEC_RISE_BASE);
   assign fall_k = wr_kind(reg_addr_in, `OEC_FALL_BASE);
   assign scr_k = wr_kind(reg_addr_in, `OEC_SCRATCH_BASE);
   assign kit_k = wr_kind(reg_addr_in, `OEC_KIT_BASE);

   // ******************************
   // Input synchronisers
   // ******************************
   logic [4:0] mon_s1_q, mon_s2_q, mon_prev_q;
   logic [1:0] line_s1_q, line_s2_q;
   logic host_s1_q, host_s2_q, rxl_s1_q, rxl_s2_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mon_s1_q <= 5'h00;
         mon_s2_q <= 5'h00;
         line_s1_q <= 2'h0;
         line_s2_q <= 2'h0;
         host_s1_q <= 1'b0;
         host_s2_q <= 1'b0;
         rxl_s1_q <= 1'b0;
         rxl_s2_q <= 1'b0;
      end else begin
         mon_s1_q <= mon_in;
         mon_s2_q <= mon_s1_q;
         line_s1_q <= line_level_in;
         line_s2_q <= line_s1_q;
         host_s1_q <= host_mode_in;
         host_s2_q <= host_s1_q;
         rxl_s1_q <= uart_rx_line_in;
         rxl_s2_q <= rxl_s1_q;
      end
   end

   // Synchroniser resets to zero, not to the pin level: edges held off
   // until the third edge after release, so a standing level is no edge
   logic [1:0] warm_q;
   logic prev_ok_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         warm_q <= 2'h0;
         prev_ok_q <= 1'b0;
         mon_prev_q <= 5'h00;
      end else begin
         warm_q <= {warm_q[0], 1'b1};
         prev_ok_q <= warm_q[1];
         mon_prev_q <= mon_s2_q;
      end
   end

   // ******************************
   // Event enables and latch
   // ******************************
   logic [4:0] rise_en_q, fall_en_q, latch_q, live, edges;
   oec_pkg::oec_mon_t mon_view;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rise_en_q <= `OEC_ENABLE_RST;
         fall_en_q <= `OEC_ENABLE_RST;
      end else if (reg_wr_in) begin
         rise_en_q <= 5'(wr_apply(rise_k, {3'h0, rise_en_q}, reg_wdata_in));
         fall_en_q <= 5'(wr_apply(fall_k, {3'h0, fall_en_q}, reg_wdata_in));
      end
   end

   // Detach only meaningful as host, so it is masked to zero otherwise
   always_comb begin
      mon_view = oec_pkg::oec_mon_t'(mon_s2_q);
      mon_view.host_detach = mon_s2_q[`OEC_HD_BIT] & host_s2_q;
   end
   assign live = 5'(mon_view);

   logic [4:0] prev_view;
   assign prev_view = {mon_prev_q[4:1], mon_prev_q[`OEC_HD_BIT] & host_s2_q};
   assign edges = prev_ok_q ?
      ((live & ~prev_view & rise_en_q) | (~live & prev_view & fall_en_q)) : 5'h00;

   logic latch_rd;
   assign latch_rd = reg_rd_in && (reg_addr_in == `OEC_LATCH_ADDR);

   // New edge wins over the clearing read
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         latch_q <= 5'h00;
      else if (latch_rd)
         latch_q <= edges;
      else
         latch_q <= latch_q | edges;
   end

   assign event_pending_out = |latch_q;

   // ******************************
   // Scratch and carkit control
   // ******************************
   logic [7:0] scratch_q;
   oec_pkg::oec_kit_t kit_q;
   logic kit_mode_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         scratch_q <= `OEC_SCRATCH_RST;
      else if (reg_wr_in)
         scratch_q <= wr_apply(scr_k, scratch_q, reg_wdata_in);
   end

   // Bit 0 and bit 7 are not stored
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         kit_q <= oec_pkg::oec_kit_t'(`OEC_KIT_RST);
      else if (reg_wr_in)
         kit_q <= oec_pkg::oec_kit_t'(6'(wr_apply(kit_k, {1'b0, kit_q, 1'b0},
                                                   reg_wdata_in) >> 1));
   end

   // Link sets it through its own register path; exit clears it here
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         kit_mode_q <= 1'b0;
      else if (kit_mode_exit_in)
         kit_mode_q <= 1'b0;
      else if (kit_mode_set_in)
         kit_mode_q <= 1'b1;
   end

   // ******************************
   // Switch outputs
   // ******************************
   logic rx_route_q, audio_any;
   assign audio_any = kit_q.left_audio_route | kit_q.right_audio_route | kit_q.mic_route;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ident_pull_low_drive_out <= 1'b0;
         dm_tx_switch_out <= 1'b0;
         dp_rx_switch_out <= 1'b0;
         left_audio_pin_switch_out <= 1'b0;
         right_mic_pin_switch_out <= 1'b0;
         se_rx_disable_out <= 1'b0;
         left_audio_uart_out <= 1'b0;
         right_mic_uart_out <= 1'b0;
         rx_route_q <= 1'b0;
      end else begin
         ident_pull_low_drive_out <= kit_q.ident_pull_low_drive;
         dm_tx_switch_out <= kit_q.uart_tx_route;
         dp_rx_switch_out <= kit_q.uart_rx_route;
         left_audio_pin_switch_out <= kit_q.left_audio_route;
         right_mic_pin_switch_out <= kit_q.right_audio_route | kit_q.mic_route;
         se_rx_disable_out <= audio_any;
         left_audio_uart_out <= kit_mode_q & kit_q.left_audio_route &
                                kit_q.uart_tx_route & uart_tx_data_in;
         right_mic_uart_out <= kit_mode_q & (kit_q.right_audio_route | kit_q.mic_route) &
                               kit_q.uart_rx_route & rxl_s2_q;
         rx_route_q <= kit_q.uart_rx_route;
      end
   end

   // Receive data idles high so the link UART sees a stop level
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         uart_rx_data_out <= 1'b1;
      else
         uart_rx_data_out <= kit_q.uart_rx_route ? rxl_s2_q : 1'b1;
   end

   assign kit_interface_mode_out = kit_mode_q;

   // ******************************
   // Read data
   // ******************************
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in) begin
         if (rise_k != oec_pkg::OEC_WR_NONE)
            reg_rdata_out <= {3'h0, rise_en_q};
         else if (fall_k != oec_pkg::OEC_WR_NONE)
            reg_rdata_out <= {3'h0, fall_en_q};
         else if (reg_addr_in == `OEC_LIVE_ADDR)
            reg_rdata_out <= {3'h0, live};
         else if (latch_rd)
            reg_rdata_out <= {3'h0, latch_q};
         else if (reg_addr_in == `OEC_DEBUG_ADDR)
            reg_rdata_out <= {6'h00, line_s2_q};
         else if (scr_k != oec_pkg::OEC_WR_NONE)
            reg_rdata_out <= scratch_q;
         else if (kit_k != oec_pkg::OEC_WR_NONE)
            reg_rdata_out <= {1'b0, kit_q, 1'b0};
         else
            reg_rdata_out <= 8'h00;
      end
   end

   // ******************************
   // Checks
   // ******************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   rise_sets_latch_a: assert property (prev_ok_q && live[1] && !prev_view[1]
      && rise_en_q[1] |=> latch_q[1]) else $error("rise event not latched");
   fall_sets_latch_a: assert property (prev_ok_q && !live[2] && prev_view[2]
      && fall_en_q[2] |=> latch_q[2]) else $error("fall event not latched");
   masked_no_latch_a: assert property (!latch_q[3] && !rise_en_q[3] && !fall_en_q[3]
      |=> !latch_q[3]) else $error("masked event latched");
   read_clears_a: assert property (latch_rd && edges == 5'h00 |=> latch_q == 5'h00)
      else $error("latch not cleared by read");
   read_returns_a: assert property (latch_rd
      |=> reg_rdata_out == {3'h0, $past(latch_q)}) else $error("latch read value wrong");
   detach_host_a: assert property (!host_s2_q |-> !live[0])
      else $error("detach seen outside host");
   set_access_a: assert property (reg_wr_in && scr_k == oec_pkg::OEC_WR_SET
      |=> scratch_q == ($past(scratch_q) | $past(reg_wdata_in)))
      else $error("scratch set wrong");
   scratch_write_a: assert property (reg_wr_in && scr_k == oec_pkg::OEC_WR_PLAIN
      |=> scratch_q == $past(reg_wdata_in)) else $error("scratch write wrong");
   rx_high_a: assert property (!rx_route_q |-> uart_rx_data_out)
      else $error("rx line not high");
   right_mic_a: assert property (kit_q.right_audio_route || kit_q.mic_route
      |=> right_mic_pin_switch_out) else $error("right mic switch open");
   se_off_a: assert property (audio_any |=> se_rx_disable_out)
      else $error("receivers not disabled");
   mode_exit_a: assert property (kit_mode_exit_in |=> !kit_interface_mode_out)
      else $error("mode not cleared");
   pending_a: assert property (|edges |=> event_pending_out)
      else $error("event not signalled");

   // Scratch clear access, readback and switch routing
   clear_access_a: assert property (reg_wr_in && scr_k == oec_pkg::OEC_WR_CLEAR
      |=> scratch_q == ($past(scratch_q) & ~$past(reg_wdata_in)))
      else $error("scratch clear wrong");
   enable_read_a: assert property (reg_rd_in && rise_k != oec_pkg::OEC_WR_NONE
      |=> reg_rdata_out == {3'h0, $past(rise_en_q)}) else $error("enable read wrong");
   live_read_a: assert property (reg_rd_in && reg_addr_in == `OEC_LIVE_ADDR
      |=> reg_rdata_out == {3'h0, $past(live)}) else $error("status read wrong");
   debug_read_a: assert property (reg_rd_in && reg_addr_in == `OEC_DEBUG_ADDR
      |=> reg_rdata_out == {6'h00, $past(line_s2_q)}) else $error("debug read wrong");
   kit_bit0_a: assert property (reg_rd_in && kit_k != oec_pkg::OEC_WR_NONE
      |=> !reg_rdata_out[0] && !reg_rdata_out[7]) else $error("kit fixed bits set");
   ident_drive_a: assert property (kit_q.ident_pull_low_drive
      |=> ident_pull_low_drive_out) else $error("ident pull not driven");
   tx_route_a: assert property (kit_q.uart_tx_route |=> dm_tx_switch_out)
      else $error("tx switch open");
   rx_route_a: assert property (kit_q.uart_rx_route |=> dp_rx_switch_out)
      else $error("rx switch open");
   left_switch_a: assert property (kit_q.left_audio_route
      |=> left_audio_pin_switch_out) else $error("left switch open");
   left_uart_a: assert property (kit_mode_q && kit_q.left_audio_route
      && kit_q.uart_tx_route && uart_tx_data_in |=> left_audio_uart_out)
      else $error("uart not on left pin");
   right_uart_a: assert property (kit_mode_q && kit_q.uart_rx_route && rxl_s2_q
      && (kit_q.right_audio_route || kit_q.mic_route) |=> right_mic_uart_out)
      else $error("uart not on right pin");

   latch_read_c: cover property (latch_rd && latch_q != 5'h00);
   read_race_c: cover property (latch_rd && edges != 5'h00);
   kit_uart_c: cover property (kit_mode_q && kit_q.uart_rx_route);
   audio_c: cover property (audio_any ##1 se_rx_disable_out);
   clear_write_c: cover property (reg_wr_in && kit_k == oec_pkg::OEC_WR_CLEAR);

endmodule
`default_nettype wire

// [verif/oec_link_model.sv]
// Link-side model: register accesses and interface mode requests.
// Assumes the register block samples its strobes on the rising clk_in edge.
`timescale 1ns/10ps
`default_nettype none
module oec_link_model (
   input wire logic clk_in,
   output logic [5:0] addr_out,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] wdata_out,
   input wire logic [7:0] rdata_in,
   output logic kit_set_out,
   output logic kit_exit_out
);
   initial begin
      addr_out = 6'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 8'h00;
      kit_set_out = 1'b0;
      kit_exit_out = 1'b0;
   end
   // Released address and data lines show inverted values so stale data never matches
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= w;
      rd_out <= !w;
      @(posedge clk_in);
      addr_out <= ~a;
      wdata_out <= ~d;
      wr_out <= 1'b0;
      rd_out <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      acc(1'b0, a, 8'h00);
      #1 q = rdata_in;
   endtask
   task automatic mode(input logic ex);
      @(posedge clk_in);
      kit_set_out <= !ex;
      kit_exit_out <= ex;
      @(posedge clk_in);
      kit_set_out <= 1'b0;
      kit_exit_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [verif/otg_event_and_carkit_regs_test.sv]
// Self-checking bench for the OTG event and carkit register block.
// Assumes oec_regs and the link model; no parameters to shorten.
`timescale 1ns/10ps
`default_nettype none
module otg_event_and_carkit_regs_test;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [5:0] addr;
   logic wr, rd, kset, kexit, host, txd, rxl;
   logic [7:0] wd, rdat;
   logic [4:0] mon = 5'h00;
   logic [1:0] line = 2'h0;
   logic mode_o, rxd_o, dm_o, dp_o, idp_o, left_o, right_o, seoff_o, pend_o, luart_o, ruart_o;
   int n_fail = 0;
   int compares = 0;
   initial begin
      host = 1'b1;
      txd = 1'b0;
      rxl = 1'b1;
   end
   oec_regs i_oec_regs (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat),
      .mon_in(mon), .line_level_in(line), .host_mode_in(host),
      .kit_mode_set_in(kset), .kit_mode_exit_in(kexit), .uart_tx_data_in(txd),
      .uart_rx_line_in(rxl), .kit_interface_mode_out(mode_o),
      .uart_rx_data_out(rxd_o), .dm_tx_switch_out(dm_o), .dp_rx_switch_out(dp_o),
      .ident_pull_low_drive_out(idp_o), .left_audio_pin_switch_out(left_o),
      .right_mic_pin_switch_out(right_o), .left_audio_uart_out(luart_o),
      .right_mic_uart_out(ruart_o), .se_rx_disable_out(seoff_o),
      .event_pending_out(pend_o));
   oec_link_model i_oec_link_model (.clk_in(clk_in), .addr_out(addr), .wr_out(wr),
      .rd_out(rd), .wdata_out(wd), .rdata_in(rdat), .kit_set_out(kset),
      .kit_exit_out(kexit));
   // ****************
   // Helpers
   // ****************
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      i_oec_link_model.rd(a, q);
      chk(n, q, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      rchk("rise", 6'h0D, 8'h1F);
      rchk("rise_at_set", 6'h0E, 8'h1F);
      rchk("rise_at_clr", 6'h0F, 8'h1F);
      rchk("fall", 6'h10, 8'h1F);
      rchk("live", 6'h13, 8'h00);
      rchk("latch", 6'h14, 8'h00);
      rchk("scratch", 6'h16, 8'h00);
      rchk("kit", 6'h19, 8'h00);
      $display("reset values done");
   endtask
   task automatic t_scratch();
      i_oec_link_model.wr(6'h16, 8'hA5);
      i_oec_link_model.wr(6'h17, 8'h5A);
      rchk("scratch_set", 6'h18, 8'hFF);
      i_oec_link_model.wr(6'h18, 8'h0F);
      rchk("scratch_clr", 6'h17, 8'hF0);
      i_oec_link_model.wr(6'h13, 8'hFF);
      rchk("live_ro", 6'h13, 8'h00);
      rchk("enables_kept", 6'h0D, 8'h1F);
      $display("scratch done");
   endtask
   task automatic t_events();
      mon <= 5'h1F;
      tick(5);
      rchk("live_all", 6'h13, 8'h1F);
      chk("pending", {7'h00, pend_o}, 8'h01);
      rchk("latch_rise", 6'h14, 8'h1F);
      rchk("latch_cleared", 6'h14, 8'h00);
      i_oec_link_model.wr(6'h12, 8'h02);
      mon <= 5'h00;
      tick(5);
      rchk("latch_fall", 6'h14, 8'h1D);
      host <= 1'b0;
      tick(3);
      mon <= 5'h01;
      tick(5);
      rchk("live_nohost", 6'h13, 8'h00);
      rchk("latch_nohost", 6'h14, 8'h00);
      i_oec_link_model.wr(6'h0F, 8'h08);
      i_oec_link_model.wr(6'h12, 8'h08);
      rchk("rise_clr", 6'h0E, 8'h17);
      mon <= 5'h0B;
      tick(5);
      rchk("latch_masked", 6'h14, 8'h02);
      // Reset with levels standing high must not fake edges
      @(posedge clk_in);
      nrst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      tick(6);
      rchk("live_after_rst", 6'h13, 8'h0A);
      rchk("latch_after_rst", 6'h14, 8'h00);
      rchk("rise_after_rst", 6'h0D, 8'h1F);
      $display("events done");
   endtask
   task automatic t_kit();
      line <= 2'h2;
      rxl <= 1'b0;
      tick(4);
      rchk("debug", 6'h15, 8'h02);
      i_oec_link_model.wr(6'h19, 8'hFF);
      i_oec_link_model.mode(1'b0);
      tick(2);
      chk("mode_on", {7'h00, mode_o}, 8'h01);
      rchk("kit_rd", 6'h1A, 8'h7E);
      chk("dm_tx", {7'h00, dm_o}, 8'h01);
      chk("dp_rx", {7'h00, dp_o}, 8'h01);
      chk("rx_data", {7'h00, rxd_o}, 8'h00);
      chk("id_pull", {7'h00, idp_o}, 8'h01);
      chk("left", {7'h00, left_o}, 8'h01);
      chk("se_off", {7'h00, seoff_o}, 8'h01);
      chk("left_uart_idle", {7'h00, luart_o}, 8'h00);
      txd <= 1'b1;
      rxl <= 1'b1;
      tick(3);
      chk("left_uart", {7'h00, luart_o}, 8'h01);
      chk("right_uart", {7'h00, ruart_o}, 8'h01);
      rxl <= 1'b0;
      i_oec_link_model.wr(6'h1B, 8'h28);
      tick(2);
      chk("rx_idle_high", {7'h00, rxd_o}, 8'h01);
      chk("right_by_mic", {7'h00, right_o}, 8'h01);
      chk("right_uart_off", {7'h00, ruart_o}, 8'h00);
      i_oec_link_model.wr(6'h1B, 8'h50);
      tick(2);
      chk("right_off", {7'h00, right_o}, 8'h00);
      chk("left_off", {7'h00, left_o}, 8'h00);
      chk("left_uart_off", {7'h00, luart_o}, 8'h00);
      chk("se_on", {7'h00, seoff_o}, 8'h00);
      i_oec_link_model.mode(1'b1);
      tick(2);
      chk("mode_off", {7'h00, mode_o}, 8'h00);
      $display("carkit done");
   endtask
   // ****************
   // Run control
   // ****************
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   initial begin
      #100us;
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge clk_in);
      nrst_in <= 1'b1;
      tick(2);
      t_reset();
      t_scratch();
      t_events();
      t_kit();
      wrap_up();
   end
endmodule
`default_nettype wire
